/* File: sdacfg_cfg.svh */
`ifndef SDACFG_CFG_SVH
`define SDACFG_CFG_SVH

// ==========================================================================
// Bus geometry
`define SDACFG_ADDR_W 14
`define SDACFG_DATA_W 16
`define SDACFG_STREAMS 32

// ==========================================================================
// Register map (word addresses on the parallel port)
`define SDACFG_BP_BASE 14'h0063
`define SDACFG_BP_LAST 14'h0082
`define SDACFG_LO_BASE 14'h0083
`define SDACFG_LO_LAST 14'h00A2

// ==========================================================================
// Field layout and reset values
`define SDACFG_BP_FIELD_W 5
`define SDACFG_LO_FIELD_W 2
`define SDACFG_BP_RESET 5'h00
`define SDACFG_LO_RESET 2'h0

// ==========================================================================
// Sampling points, in quarters of a bit
`define SDACFG_SP_FRAC 3'h3
`define SDACFG_SP_00 3'h3
`define SDACFG_SP_01 3'h4
`define SDACFG_SP_10 3'h1
`define SDACFG_SP_11 3'h2

// ==========================================================================
// Output advancement, in internal clock cycles
`define SDACFG_ADV_00 3'h0
`define SDACFG_ADV_01 3'h2
`define SDACFG_ADV_10 3'h4
`define SDACFG_ADV_11 3'h6

// ==========================================================================
// Frame timing
`define SDACFG_CLK_PERIOD_NS 10
`define SDACFG_FRAME_NS 125000
`define SDACFG_FRAME_CYCLES (`SDACFG_FRAME_NS / `SDACFG_CLK_PERIOD_NS)
`define SDACFG_POS_W 14

`endif

/* File: sdacfg_pkg.sv */
package sdacfg_pkg;
    `include "sdacfg_cfg.svh"

    // ======================================================================
    // Types
    typedef logic [`SDACFG_ADDR_W-1:0] sdacfg_addr_t;
    typedef logic [`SDACFG_DATA_W-1:0] sdacfg_data_t;
    typedef logic [`SDACFG_BP_FIELD_W-1:0] sdacfg_bp_field_t;
    typedef logic [`SDACFG_LO_FIELD_W-1:0] sdacfg_lo_field_t;
    typedef logic [4:0] sdacfg_delay_t;
    typedef logic [2:0] sdacfg_qtr_t;
    typedef logic [2:0] sdacfg_adv_t;
    typedef logic [`SDACFG_POS_W-1:0] sdacfg_pos_t;

    // ======================================================================
    // Decoders
    function automatic sdacfg_delay_t sdacfg_bp_delay(input sdacfg_bp_field_t f,
                                                      input logic sel);
        return sel ? {f[4:2], 2'b00} : f;
    endfunction

    function automatic sdacfg_qtr_t sdacfg_bp_sample(input sdacfg_bp_field_t f,
                                                     input logic sel);
        sdacfg_qtr_t q;
        q = `SDACFG_SP_FRAC;
        if (sel) begin
            unique case (f[1:0])
                2'b00: q = `SDACFG_SP_00;
                2'b01: q = `SDACFG_SP_01;
                2'b10: q = `SDACFG_SP_10;
                2'b11: q = `SDACFG_SP_11;
            endcase
        end
        return q;
    endfunction

    function automatic sdacfg_adv_t sdacfg_adv(input sdacfg_lo_field_t f);
        sdacfg_adv_t a;
        a = `SDACFG_ADV_00;
        unique case (f)
            2'b00: a = `SDACFG_ADV_00;
            2'b01: a = `SDACFG_ADV_01;
            2'b10: a = `SDACFG_ADV_10;
            2'b11: a = `SDACFG_ADV_11;
        endcase
        return a;
    endfunction
endpackage

/* File: sdacfg_frame_if.sv */
`timescale 1ns/100ps
`include "sdacfg_cfg.svh"
interface sdacfg_frame_if;
    logic [`SDACFG_POS_W-1:0] pos;
    logic boundary;
    modport timer(output pos, output boundary);
    modport user(input pos, input boundary);
endinterface

/* File: sdacfg_frame_timer.sv */
`timescale 1ns/100ps
`include "sdacfg_cfg.svh"
module sdacfg_frame_timer #(
    parameter int FRAME_CYCLES = `SDACFG_FRAME_CYCLES
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic frame_ref_i,
    sdacfg_frame_if.timer frm
);
    import sdacfg_pkg::*;

    sdacfg_pos_t pos_reg;

    // ======================================================================
    // Position within the output frame, realigned by the frame reference
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pos_reg <= '0;
        end else if (frame_ref_i || pos_reg == sdacfg_pos_t'(FRAME_CYCLES - 1)) begin
            pos_reg <= '0;
        end else begin
            pos_reg <= pos_reg + sdacfg_pos_t'(1);
        end
    end

    assign frm.pos = pos_reg;
    assign frm.boundary = (pos_reg == '0);
endmodule

/* File: sdacfg_stream_delay_advance.sv */
`timescale 1ns/100ps
`include "sdacfg_cfg.svh"

module sdacfg_stream_delay_advance #(
    parameter int STREAMS = `SDACFG_STREAMS,
    parameter int FRAME_CYCLES = `SDACFG_FRAME_CYCLES
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic cpu_sel_i,
    input wire logic cpu_wr_i,
    input sdacfg_pkg::sdacfg_addr_t cpu_addr_i,
    input sdacfg_pkg::sdacfg_data_t cpu_wdata_i,
    output sdacfg_pkg::sdacfg_data_t cpu_rdata_o,
    output logic cpu_ack_o,
    input wire logic sample_point_select_i,
    input wire logic frame_ref_i,
    output sdacfg_pkg::sdacfg_delay_t bp_delay_quarters_o [STREAMS],
    output sdacfg_pkg::sdacfg_qtr_t bp_sample_point_o [STREAMS],
    output sdacfg_pkg::sdacfg_adv_t lo_advance_cycles_o [STREAMS],
    output logic [STREAMS-1:0] lo_stream_start_o,
    output logic generated_frame_pulse_out_o
);
    import sdacfg_pkg::*;

    // ======================================================================
    // Storage
    sdacfg_bp_field_t bp_field_reg [STREAMS];
    sdacfg_lo_field_t lo_field_reg [STREAMS];
    sdacfg_data_t rdata_reg;
    logic ack_reg;
    logic [STREAMS-1:0] start_reg;
    logic frame_pulse_reg;
    sdacfg_delay_t delay_reg [STREAMS];
    sdacfg_qtr_t sample_reg [STREAMS];
    sdacfg_adv_t adv_reg [STREAMS];

    sdacfg_addr_t bp_off;
    sdacfg_addr_t lo_off;
    logic [4:0] bp_idx;
    logic [4:0] lo_idx;
    logic bp_hit;
    logic lo_hit;
    logic wr_strobe;
    logic rd_strobe;

    sdacfg_frame_if frm ();

    sdacfg_frame_timer #(
        .FRAME_CYCLES(FRAME_CYCLES)
    ) u_timer (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .frame_ref_i(frame_ref_i),
        .frm(frm)
    );

    // ======================================================================
    // Address decode
    function automatic logic in_window(input sdacfg_addr_t a, input sdacfg_addr_t lo,
                                       input sdacfg_addr_t hi);
        return (a >= lo) && (a <= hi);
    endfunction

    function automatic sdacfg_pos_t start_pos(input sdacfg_adv_t adv);
        sdacfg_pos_t p;
        p = '0;
        if (adv != '0) begin
            p = sdacfg_pos_t'(FRAME_CYCLES) - sdacfg_pos_t'(adv);
        end
        return p;
    endfunction

    assign bp_off = cpu_addr_i - `SDACFG_BP_BASE;
    assign lo_off = cpu_addr_i - `SDACFG_LO_BASE;
    assign bp_idx = bp_off[4:0];
    assign lo_idx = lo_off[4:0];
    assign bp_hit = in_window(cpu_addr_i, `SDACFG_BP_BASE, `SDACFG_BP_LAST);
    assign lo_hit = in_window(cpu_addr_i, `SDACFG_LO_BASE, `SDACFG_LO_LAST);
    assign wr_strobe = cpu_sel_i && cpu_wr_i;
    assign rd_strobe = cpu_sel_i && !cpu_wr_i;

    // ======================================================================
    // Backplane input delay registers
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < STREAMS; i++) begin
                bp_field_reg[i] <= `SDACFG_BP_RESET;
            end
        end else if (wr_strobe && bp_hit) begin
            // Only the field bits are kept; upper bits are expected zero
            bp_field_reg[bp_idx] <= cpu_wdata_i[`SDACFG_BP_FIELD_W-1:0];
        end
    end

    // ======================================================================
    // Local output advancement registers
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < STREAMS; i++) begin
                lo_field_reg[i] <= `SDACFG_LO_RESET;
            end
        end else if (wr_strobe && lo_hit) begin
            lo_field_reg[lo_idx] <= cpu_wdata_i[`SDACFG_LO_FIELD_W-1:0];
        end
    end

    // ======================================================================
    // Read port: one-cycle answer, unmapped words read as zero
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_reg <= '0;
        end else if (rd_strobe) begin
            rdata_reg <= '0;
            if (bp_hit) begin
                rdata_reg <= sdacfg_data_t'(bp_field_reg[bp_idx]);
            end else if (lo_hit) begin
                rdata_reg <= sdacfg_data_t'(lo_field_reg[lo_idx]);
            end
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= cpu_sel_i;
        end
    end

    // ======================================================================
    // Per-stream decode of delay, sampling point and advancement
    generate
        for (genvar g = 0; g < STREAMS; g++) begin : g_stream
            always_ff @(posedge mclk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    delay_reg[g] <= '0;
                    sample_reg[g] <= `SDACFG_SP_FRAC;
                end else begin
                    // Live select: all fields change meaning together
                    delay_reg[g] <= sdacfg_bp_delay(bp_field_reg[g],
                                                    sample_point_select_i);
                    sample_reg[g] <= sdacfg_bp_sample(bp_field_reg[g],
                                                      sample_point_select_i);
                end
            end

            always_ff @(posedge mclk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    adv_reg[g] <= '0;
                    start_reg[g] <= 1'b0;
                end else begin
                    adv_reg[g] <= sdacfg_adv(lo_field_reg[g]);
                    // Start leads the frame boundary by the advance count
                    start_reg[g] <= (frm.pos == start_pos(sdacfg_adv(lo_field_reg[g])));
                end
            end

            assign bp_delay_quarters_o[g] = delay_reg[g];
            assign bp_sample_point_o[g] = sample_reg[g];
            assign lo_advance_cycles_o[g] = adv_reg[g];
        end
    endgenerate

    // ======================================================================
    // Frame pulse, aligned with a zero-advance stream start
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            frame_pulse_reg <= 1'b0;
        end else begin
            frame_pulse_reg <= frm.boundary;
        end
    end

    assign cpu_rdata_o = rdata_reg;
    assign cpu_ack_o = ack_reg;
    assign lo_stream_start_o = start_reg;
    assign generated_frame_pulse_out_o = frame_pulse_reg;

    // ======================================================================
    // Checks
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!arst_n_i);

    logic first_reg;

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            first_reg <= 1'b1;
        end else begin
            first_reg <= 1'b0;
        end
    end

    a_reset_fields_zero: assert property (
        first_reg |-> bp_field_reg[0] == '0 && lo_field_reg[STREAMS-1] == '0
            && bp_sample_point_o[0] == `SDACFG_SP_FRAC
    ) else $error("fields not zero after reset");

    a_bp_write_lands: assert property (
        (wr_strobe && bp_hit) |=> bp_field_reg[$past(bp_idx)] == $past(cpu_wdata_i[4:0])
    ) else $error("backplane delay write lost");

    a_lo_write_lands: assert property (
        (wr_strobe && lo_hit) |=> lo_field_reg[$past(lo_idx)] == $past(cpu_wdata_i[1:0])
    ) else $error("output advance write lost");

    a_lo_readback: assert property (
        (rd_strobe && cpu_addr_i == `SDACFG_LO_LAST)
            |=> cpu_ack_o && cpu_rdata_o == sdacfg_data_t'($past(lo_field_reg[STREAMS-1]))
    ) else $error("advance readback wrong");

    a_frac_delay: assert property (
        !sample_point_select_i |=> bp_delay_quarters_o[3] == $past(bp_field_reg[3])
    ) else $error("fractional delay not field value");

    a_frac_sample_fixed: assert property (
        !sample_point_select_i |=> bp_sample_point_o[5] == 3'h3
    ) else $error("fractional sample point not 3/4");

    a_point_whole_delay: assert property (
        sample_point_select_i |=> bp_delay_quarters_o[7][1:0] == 2'b00
            && bp_delay_quarters_o[7][4:2] == $past(bp_field_reg[7][4:2])
    ) else $error("integer delay wrong");

    a_point_sample_map: assert property (
        (sample_point_select_i && bp_field_reg[2][1:0] == 2'b10)
            |=> bp_sample_point_o[2] == 3'h1
    ) else $error("sample point 10 not 1/4");

    a_mode_toggle_live: assert property (
        ($rose(sample_point_select_i) && $stable(bp_field_reg[1]) && bp_field_reg[1] == 5'h01)
            |=> bp_sample_point_o[1] == 3'h4 && bp_delay_quarters_o[1] == 5'h00
    ) else $error("select toggle not applied");

    a_adv_map: assert property (
        ##1 lo_advance_cycles_o[4] == {$past(lo_field_reg[4]), 1'b0}
    ) else $error("advance count wrong");

    a_zero_adv_aligned: assert property (
        (frm.boundary && lo_field_reg[0] == 2'b00)
            |=> lo_stream_start_o[0] && generated_frame_pulse_out_o
    ) else $error("zero advance not aligned");

    a_adv_six_leads: assert property (
        (lo_field_reg[0] == 2'b11 && !frame_ref_i && frm.pos == sdacfg_pos_t'(FRAME_CYCLES - 6))
            |=> lo_stream_start_o[0] && !generated_frame_pulse_out_o
    ) else $error("six-cycle advance misplaced");

    // ======================================================================
    // Register port checks
    a_ack_follows_sel: assert property (
        cpu_sel_i |=> cpu_ack_o
    ) else $error("access not acknowledged");

    a_ack_no_stray: assert property (
        !cpu_sel_i |=> !cpu_ack_o
    ) else $error("acknowledge without access");

    a_bp_readback: assert property (
        (rd_strobe && bp_hit)
            |=> cpu_rdata_o == sdacfg_data_t'($past(bp_field_reg[bp_idx]))
    ) else $error("delay readback wrong");

    a_unmapped_zero: assert property (
        (rd_strobe && !bp_hit && !lo_hit) |=> cpu_rdata_o == '0
    ) else $error("unmapped read not zero");

    a_upper_bits_zero: assert property (
        rd_strobe |=> cpu_rdata_o[15:5] == '0
    ) else $error("reserved delay bits not zero");

    a_lo_upper_zero: assert property (
        (rd_strobe && lo_hit) |=> cpu_rdata_o[15:2] == '0
    ) else $error("reserved advance bits not zero");

    a_rdata_holds: assert property (
        !rd_strobe |=> $stable(cpu_rdata_o)
    ) else $error("read data moved without read");

    a_bp_write_isolated: assert property (
        (wr_strobe && bp_hit) |=> $stable(lo_field_reg[0])
    ) else $error("delay write disturbed advance");

    a_lo_write_isolated: assert property (
        (wr_strobe && lo_hit) |=> $stable(bp_field_reg[0])
    ) else $error("advance write disturbed delay");

    // ======================================================================
    // Decode and frame checks
    a_frac_delay_max: assert property (
        !sample_point_select_i |=> bp_delay_quarters_o[31] == $past(bp_field_reg[31])
    ) else $error("largest fractional delay wrong");

    a_whole_delay_max: assert property (
        sample_point_select_i
            |=> bp_delay_quarters_o[31] == {$past(bp_field_reg[31][4:2]), 2'b00}
    ) else $error("largest whole delay wrong");

    a_point_map_00: assert property (
        (sample_point_select_i && bp_field_reg[4][1:0] == 2'b00)
            |=> bp_sample_point_o[4] == 3'h3
    ) else $error("sample point 00 not 3/4");

    a_point_map_11: assert property (
        (sample_point_select_i && bp_field_reg[3][1:0] == 2'b11)
            |=> bp_sample_point_o[3] == 3'h2
    ) else $error("sample point 11 not 2/4");

    a_mode_fall_live: assert property (
        ($fell(sample_point_select_i) && $stable(bp_field_reg[1]) && bp_field_reg[1] == 5'h01)
            |=> bp_sample_point_o[1] == 3'h3 && bp_delay_quarters_o[1] == 5'h01
    ) else $error("select fall not applied");

    a_adv_none_zero: assert property (
        lo_field_reg[STREAMS-1] == 2'b00 |=> lo_advance_cycles_o[STREAMS-1] == 3'h0
    ) else $error("zero advance not zero");

    a_pulse_on_boundary: assert property (
        frm.boundary |=> generated_frame_pulse_out_o
    ) else $error("frame pulse missing at boundary");

    // A frame reference landing on position zero legally repeats the boundary
    a_pulse_one_cycle: assert property (
        (generated_frame_pulse_out_o && !$past(frame_ref_i)) |=> !generated_frame_pulse_out_o
    ) else $error("frame pulse longer than a cycle");

    a_start_one_cycle: assert property (
        (lo_stream_start_o[0] && !$past(frame_ref_i)) |=> !lo_stream_start_o[0]
    ) else $error("stream start longer than a cycle");

    c_bp_write: cover property (wr_strobe && bp_hit);
    c_mode_toggle: cover property ($rose(sample_point_select_i));
    c_adv_start: cover property (lo_stream_start_o[0] && lo_advance_cycles_o[0] == 3'h6);
    c_frame_pulse: cover property (generated_frame_pulse_out_o);
    c_select_fall: cover property ($fell(sample_point_select_i));
endmodule

/* File: sdacfg_frame_src.sv */
`timescale 1ns/100ps
// =====================================================================
// Far-side frame reference, first pulse off the free-running phase
module sdacfg_frame_src #(
    parameter int FRAME_CYCLES = 64,
    parameter int FIRST_GAP = 20
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    output logic frame_ref_o
);
    int cnt_reg;

    // Periodic boundary marker that the output frame is measured from
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_reg <= FIRST_GAP;
        end else begin
            cnt_reg <= (cnt_reg == 0) ? FRAME_CYCLES - 1 : cnt_reg - 1;
        end
    end

    assign frame_ref_o = arst_n_i && (cnt_reg == 0);
endmodule

/* File: sdacfg_stream_delay_advance_bench.sv */
`timescale 1ns/100ps
module sdacfg_stream_delay_advance_bench;
    import sdacfg_pkg::*;
    localparam int FC = 64;
    logic mclk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic sel = 1'b0;
    logic wr = 1'b0;
    sdacfg_addr_t addr = '0;
    sdacfg_data_t wdata = '0;
    logic smode = 1'b0;
    sdacfg_data_t rdata;
    logic ack;
    logic fref;
    logic fpulse;
    sdacfg_delay_t dq [32];
    sdacfg_qtr_t sp [32];
    sdacfg_adv_t adv [32];
    logic [31:0] starts;
    logic [5:0][31:0] hist;
    int n_errors = 0;
    int n_tests = 0;
    int seed = 63676;
    int bp_m [32];
    int lo_m [32];
    int spt [4] = '{3, 4, 1, 2};
    int off;
    logic [15:0] r;

    always #5 mclk_i = ~mclk_i;

    // Start history, newest first, for the advance check
    always @(negedge mclk_i) hist <= {hist[4:0], starts};

    sdacfg_stream_delay_advance #(.STREAMS(32), .FRAME_CYCLES(FC)) dut_u (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .cpu_sel_i(sel),
        .cpu_wr_i(wr),
        .cpu_addr_i(addr),
        .cpu_wdata_i(wdata),
        .cpu_rdata_o(rdata),
        .cpu_ack_o(ack),
        .sample_point_select_i(smode),
        .frame_ref_i(fref),
        .bp_delay_quarters_o(dq),
        .bp_sample_point_o(sp),
        .lo_advance_cycles_o(adv),
        .lo_stream_start_o(starts),
        .generated_frame_pulse_out_o(fpulse)
    );

    sdacfg_frame_src #(.FRAME_CYCLES(FC), .FIRST_GAP(20)) frame_src_u (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .frame_ref_o(fref)
    );

    // =====================================================================
    // Checking and bus tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [15:0] mexp(input int a);
        if (a >= 'h63 && a <= 'h82) return 16'(bp_m[a - 'h63]);
        if (a >= 'h83 && a <= 'hA2) return 16'(lo_m[a - 'h83]);
        return 16'h0000;
    endfunction

    task automatic acc(input logic w, input int a, input int d, output logic [15:0] q);
        @(posedge mclk_i);
        sel <= 1'b1;
        wr <= w;
        addr <= a[13:0];
        wdata <= d[15:0];
        @(posedge mclk_i);
        sel <= 1'b0;
        @(negedge mclk_i);
        chk(16'(ack), 16'h0001);
        q = rdata;
    endtask

    task automatic rd(input int a);
        acc(1'b0, a, 0, r);
        chk(r, mexp(a));
    endtask

    task automatic wrr(input int a, input int d);
        acc(1'b1, a, d, r);
        if (a >= 'h63 && a <= 'h82) bp_m[a - 'h63] = d & 31;
        if (a >= 'h83 && a <= 'hA2) lo_m[a - 'h83] = d & 3;
    endtask

    task automatic dec();
        for (int n = 0; n < 32; n++) begin
            chk(16'(dq[n]), 16'(smode ? (bp_m[n] >> 2) * 4 : bp_m[n]));
            chk(16'(sp[n]), 16'(smode ? spt[bp_m[n] & 3] : 3));
            chk(16'(adv[n]), 16'(2 * lo_m[n]));
        end
    endtask

    task automatic frm();
        logic [6:0] col;
        for (int k = 0; k < 200 && fpulse !== 1'b1; k++) @(negedge mclk_i);
        chk(16'(fpulse), 16'h0001);
        for (int n = 0; n < 32; n++) begin
            col[0] = starts[n];
            for (int j = 0; j < 6; j++) col[j + 1] = hist[j][n];
            chk(16'(col), 16'(7'h01 << (2 * lo_m[n])));
        end
        @(negedge mclk_i);
    endtask

    task automatic summarize();
        if (n_errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // =====================================================================
    // Main sequence
    initial begin
        for (int n = 0; n < 32; n++) begin
            bp_m[n] = 0;
            lo_m[n] = 0;
        end
        repeat (4) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        for (int a = 'h62; a <= 'hA3; a++) rd(a);
        dec();
        wrr('h62, $random(seed));
        wrr('hA3, $random(seed) & 3);
        rd('h62);
        rd('hA3);
        off = $random(seed) & 3;
        for (int n = 0; n < 32; n++) begin
            wrr('h63 + n, n);
            wrr('h83 + n, (n + off) & 3);
        end
        for (int a = 'h63; a <= 'hA2; a++) rd(a);
        for (int s = 0; s < 3; s++) begin
            @(posedge mclk_i);
            smode <= s[0];
            repeat (3) @(negedge mclk_i);
            dec();
        end
        repeat (2 * FC) @(negedge mclk_i);
        frm();
        frm();
        wrr('h83, 3);
        frm();
        @(posedge mclk_i);
        arst_n_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        for (int n = 0; n < 32; n++) begin
            bp_m[n] = 0;
            lo_m[n] = 0;
        end
        rd('h63);
        rd('h83);
        dec();
        summarize();
    end

    // Cut a hang short well beyond the expected run of under a thousand cycles
    initial begin
        #200000;
        n_errors++;
        summarize();
    end
endmodule
